//--- rtl/sync_barrier_option_decoder.sv
// Summary of operation
// - a barrier whose condition check fails is retired with no request.
// - options 0001, 0010, 0011 select outer shareable reads, writes, all.
// - options 0101, 0110, 0111 select non-shareable reads, writes, all.
// - options 1001, 1010, 1011 select inner shareable reads, writes, all.
// - options 1101 and 1110 select full system reads and writes.
// - every other option decodes as full system covering all accesses.
// - the upgrade applies only with a hypervisor, non-secure, below it.
// - upgrade field 11 forces the domain to full system.
// - upgrade field 10 raises any domain short of full system to outer.
// - upgrade field 01 raises non-shareable to inner, others unchanged.
// - option 1100 at the hypervisor level issues a full barrier.
// - a hypervisor full barrier ignores level and machine identifier.
// - option 1100 below the hypervisor acts as a full system barrier.
// - the full barrier is recognised by option value 12 at the hypervisor level.
// - lower levels order per machine identifier, hypervisor among itself.
// - reserved options execute as a full system barrier.
`timescale 1ns/10ps
`include "sync_barrier_defs.svh"

module sync_barrier_option_decoder #(
  parameter int VIRTUAL_MACHINE_IDENTIFIER_W   = 8,
  parameter int CNT_W    = 16,
  parameter bit HAVE_HYP = 1'b1
) (
  input  wire logic                              CLK,
  input  wire logic                              RSTN,
  // issue side from the pipeline
  input  wire logic                              ISSUE_VALID,
  output      logic                              ISSUE_READY,
  input  wire logic                       [31:0] INSTR,
  input  wire logic                              COND_PASS,
  input  wire logic                        [1:0] LEVEL,
  input  wire logic                              SECURE,
  input  wire logic                 [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] VIRTUAL_MACHINE_IDENTIFIER,
  // request side to the memory ordering logic
  output      logic                              BAR_REQ,
  input  wire logic                              BAR_DONE,
  output      logic                        [1:0] BAR_DOMAIN,
  output      logic                        [1:0] BAR_TYPES,
  output      logic                              BAR_FULL,
  output      logic                        [1:0] BAR_SCOPE,
  output      logic                 [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] BAR_VIRTUAL_MACHINE_IDENTIFIER,
  output      logic                              RETIRE,
  // register bus
  input  wire logic                              HSEL,
  input  wire logic                       [31:0] HADDR,
  input  wire logic                        [1:0] HTRANS,
  input  wire logic                              HWRITE,
  input  wire logic                        [2:0] HSIZE,
  input  wire logic                       [31:0] HWDATA,
  input  wire logic                              HREADY,
  output      logic                              HREADYOUT,
  output      logic                              HRESP,
  output      logic                       [31:0] HRDATA
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  // identifiers wider than the status word cannot be reported
  if (VIRTUAL_MACHINE_IDENTIFIER_W < 1 || VIRTUAL_MACHINE_IDENTIFIER_W > 16) begin : g_virtual_machine_identifier_chk
    $error("VIRTUAL_MACHINE_IDENTIFIER_W must lie between 1 and 16");
  end
  // counters are read back in one bus word
  if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_chk
    $error("CNT_W must lie between 1 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  barrier_req_if                  req ();
  sync_barrier_pkg::state_t       state_q;
  sync_barrier_pkg::level_t       level;
  sync_barrier_pkg::scope_t       scope;
  logic                     [3:0] option;
  logic                           accept;
  logic                           full_sel;
  logic                     [1:0] ctrl_q;
  logic                     [1:0] ctrl_d;
  logic                     [1:0] dom_q;
  logic                     [1:0] typ_q;
  logic                           full_q;
  logic                     [1:0] scope_q;
  logic              [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] virtual_machine_identifier_q;
  logic                           retire_q;
  logic               [CNT_W-1:0] done_cnt_q;
  logic               [CNT_W-1:0] skip_cnt_q;
  logic                           ahb_wr_q;
  logic          [`ADDR_W-1:0]    ahb_addr_q;
  logic                           ahb_req;
  logic                    [31:0] rd_word;
  logic                    [31:0] status_word;
  logic                    [31:0] done_word;
  logic                    [31:0] skip_word;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the incoming instruction

  // the option field sits at the same bits in both instruction sets
  assign option = INSTR[`OPT_MSB:`OPT_LSB];

  // unknown level codes are treated as the hypervisor level
  always_comb begin
    unique case (LEVEL)
      2'h0:    level = sync_barrier_pkg::APPLICATION_LEVEL;
      2'h1:    level = sync_barrier_pkg::KERNEL_LEVEL;
      default: level = sync_barrier_pkg::HYPERVISOR_LEVEL;
    endcase
  end

  // feed the option map
  assign req.option      = option;
  assign req.level       = level;
  assign req.secure      = SECURE;
  assign req.hyp_present = HAVE_HYP;
  assign req.bsu         = ctrl_q;

  // domain and access class lookup with the upgrade applied
  barrier_option_map u_map (
    .req (req)
  );

  // only code 12 together with the hypervisor level makes a full barrier
  assign full_sel = (option == `OPT_FULL_BARRIER) &&
                    (level == sync_barrier_pkg::HYPERVISOR_LEVEL);

  // ordering scope: full barrier ignores level and identifier
  always_comb begin
    if (full_sel) begin
      scope = sync_barrier_pkg::SCOPE_EVERY;
    end else if (level == sync_barrier_pkg::HYPERVISOR_LEVEL) begin
      scope = sync_barrier_pkg::SCOPE_HYP_ONLY;
    end else begin
      scope = sync_barrier_pkg::SCOPE_SAME_VIRTUAL_MACHINE_IDENTIFIER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request sequencing

  // one barrier in flight; the pipeline is held while it drains
  assign ISSUE_READY = (state_q == sync_barrier_pkg::ST_IDLE);
  assign accept      = ISSUE_VALID && ISSUE_READY;
  assign BAR_REQ     = (state_q == sync_barrier_pkg::ST_WAIT);

  // a failed condition never leaves idle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= sync_barrier_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        sync_barrier_pkg::ST_IDLE: begin
          if (accept && COND_PASS) begin
            state_q <= sync_barrier_pkg::ST_WAIT;
          end
        end
        sync_barrier_pkg::ST_WAIT: begin
          if (BAR_DONE) begin
            state_q <= sync_barrier_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // request attributes are held stable for the whole wait
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dom_q   <= 2'h3;
      typ_q   <= 2'h3;
      full_q  <= 1'b0;
      scope_q <= 2'h0;
      virtual_machine_identifier_q  <= '0;
    end else if (accept && COND_PASS) begin
      dom_q   <= req.domain;
      typ_q   <= req.types;
      full_q  <= full_sel;
      scope_q <= scope;
      virtual_machine_identifier_q  <= VIRTUAL_MACHINE_IDENTIFIER;
    end
  end

  // retire pulse: completion, or straight away for a failed condition
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      retire_q <= 1'b0;
    end else begin
      retire_q <= (accept && !COND_PASS) || (BAR_REQ && BAR_DONE);
    end
  end

  // completed and skipped barrier counters, wrapping
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      done_cnt_q <= '0;
      skip_cnt_q <= '0;
    end else begin
      if (BAR_REQ && BAR_DONE) begin
        done_cnt_q <= done_cnt_q + 1'b1;
      end
      if (accept && !COND_PASS) begin
        skip_cnt_q <= skip_cnt_q + 1'b1;
      end
    end
  end

  // request outputs straight from the held attributes
  assign BAR_DOMAIN = dom_q;
  assign BAR_TYPES  = typ_q;
  assign BAR_FULL   = full_q;
  assign BAR_SCOPE  = scope_q;
  assign BAR_VIRTUAL_MACHINE_IDENTIFIER   = virtual_machine_identifier_q;
  assign RETIRE     = retire_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  // a transfer is taken when selected, active and the bus is ready
  assign ahb_req = HSEL && HREADY && HTRANS[1];

  // address phase capture for the following write data phase
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ahb_wr_q   <= 1'b0;
      ahb_addr_q <= '0;
    end else if (HREADY) begin
      // writes outside the four decoded words are dropped here
      ahb_wr_q   <= ahb_req && HWRITE && (HADDR[31:`ADDR_W] == '0);
      ahb_addr_q <= HADDR[`ADDR_W-1:0];
    end
  end

  // write lands in the data phase; only the control word is writable
  always_comb begin
    ctrl_d = ctrl_q;
    if (ahb_wr_q && ahb_addr_q == `REG_CTRL) begin
      ctrl_d = HWDATA[`CTRL_BSU_MSB:`CTRL_BSU_LSB];
    end
  end

  // control register holding the upgrade field
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= `CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // status: busy, domain, class, full flag, scope, held identifier
  always_comb begin
    status_word        = 32'h0;
    status_word[0]     = BAR_REQ;
    status_word[2:1]   = dom_q;
    status_word[4:3]   = typ_q;
    status_word[5]     = full_q;
    status_word[7:6]   = scope_q;
    status_word[8 +: VIRTUAL_MACHINE_IDENTIFIER_W] = virtual_machine_identifier_q;
    done_word          = 32'h0;
    done_word[CNT_W-1:0] = done_cnt_q;
    skip_word          = 32'h0;
    skip_word[CNT_W-1:0] = skip_cnt_q;
  end

  // read mux; the control word is forwarded so a write is seen at once
  always_comb begin
    unique case (HADDR[`ADDR_W-1:0])
      `REG_CTRL:       rd_word = {30'h0, ctrl_d};
      `REG_STATUS:     rd_word = status_word;
      `REG_DONE_COUNT: rd_word = done_word;
      `REG_SKIP_COUNT: rd_word = skip_word;
      default:         rd_word = 32'h0;
    endcase
    if (HADDR[31:`ADDR_W] != '0) begin
      rd_word = 32'h0; // unmapped reads as zero
    end
  end

  // read data registered at the address phase, shown in the data phase
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA <= 32'h0;
    end else if (ahb_req && !HWRITE) begin
      HRDATA <= rd_word;
    end
  end

  // zero wait states and always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

endmodule : sync_barrier_option_decoder

//--- rtl/sync_barrier_defs.svh
`ifndef SYNC_BARRIER_DEFS_SVH
`define SYNC_BARRIER_DEFS_SVH

// option codes carried in instruction bits 3:0
`define OPT_OUTER_READS        4'h1
`define OPT_OUTER_WRITES       4'h2
`define OPT_OUTER_ALL          4'h3
`define OPT_NONSH_READS        4'h5
`define OPT_NONSH_WRITES       4'h6
`define OPT_NONSH_ALL          4'h7
`define OPT_INNER_READS        4'h9
`define OPT_INNER_WRITES       4'hA
`define OPT_INNER_ALL          4'hB
`define OPT_FULL_BARRIER       4'hC
`define OPT_SYSTEM_READS       4'hD
`define OPT_SYSTEM_WRITES      4'hE
`define OPT_MSB                3
`define OPT_LSB                0

// barrier_shareability_upgrade field values
`define BSU_INNER              2'h1
`define BSU_OUTER              2'h2
`define BSU_SYSTEM             2'h3

// register byte offsets
`define REG_CTRL               4'h0
`define REG_STATUS             4'h4
`define REG_DONE_COUNT         4'h8
`define REG_SKIP_COUNT         4'hC
`define ADDR_W                 4

// control register layout and reset value
`define CTRL_BSU_LSB           0
`define CTRL_BSU_MSB           1
`define CTRL_RESET             2'h0

`endif

//--- rtl/sync_barrier_pkg.sv
package sync_barrier_pkg;

  // shareability domain of a barrier request
  typedef enum logic [1:0] {
    DOM_NONSHAREABLE = 2'h0,
    DOM_INNER        = 2'h1,
    DOM_OUTER        = 2'h2,
    DOM_FULL_SYSTEM  = 2'h3
  } domain_t;

  // access class ordered by a barrier
  typedef enum logic [1:0] {
    TYP_READS  = 2'h1,
    TYP_WRITES = 2'h2,
    TYP_ALL    = 2'h3
  } types_t;

  // exception level of the issuing instruction
  typedef enum logic [1:0] {
    APPLICATION_LEVEL = 2'h0,
    KERNEL_LEVEL      = 2'h1,
    HYPERVISOR_LEVEL  = 2'h2
  } level_t;

  // which accesses a barrier is ordered against
  typedef enum logic [1:0] {
    SCOPE_SAME_VIRTUAL_MACHINE_IDENTIFIER = 2'h0,
    SCOPE_HYP_ONLY  = 2'h1,
    SCOPE_EVERY     = 2'h2
  } scope_t;

  // request sequencer states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } state_t;

endpackage : sync_barrier_pkg

//--- rtl/barrier_req_if.sv
`timescale 1ns/10ps

// decode inputs and the resulting domain and access class
interface barrier_req_if;
  logic                        [3:0] option;
  sync_barrier_pkg::level_t          level;
  logic                              secure;
  logic                              hyp_present;
  logic                        [1:0] bsu;
  sync_barrier_pkg::domain_t         domain;
  sync_barrier_pkg::types_t          types;

  modport map  (input  option, level, secure, hyp_present, bsu,
                output domain, types);
  modport user (output option, level, secure, hyp_present, bsu,
                input  domain, types);
endinterface : barrier_req_if

//--- rtl/barrier_option_map.sv
`timescale 1ns/10ps
`include "sync_barrier_defs.svh"

module barrier_option_map (
  barrier_req_if.map req
);

  sync_barrier_pkg::domain_t dom;
  logic                      upgrade;

  // option field to domain and access class, then hypervisor upgrade
  always_comb begin
    dom       = sync_barrier_pkg::DOM_FULL_SYSTEM;
    req.types = sync_barrier_pkg::TYP_ALL;
    unique case (req.option)
      `OPT_OUTER_READS:   begin dom = sync_barrier_pkg::DOM_OUTER; req.types = sync_barrier_pkg::TYP_READS;  end
      `OPT_OUTER_WRITES:  begin dom = sync_barrier_pkg::DOM_OUTER; req.types = sync_barrier_pkg::TYP_WRITES; end
      `OPT_OUTER_ALL:     begin dom = sync_barrier_pkg::DOM_OUTER; req.types = sync_barrier_pkg::TYP_ALL;    end
      `OPT_NONSH_READS:   begin dom = sync_barrier_pkg::DOM_NONSHAREABLE; req.types = sync_barrier_pkg::TYP_READS;  end
      `OPT_NONSH_WRITES:  begin dom = sync_barrier_pkg::DOM_NONSHAREABLE; req.types = sync_barrier_pkg::TYP_WRITES; end
      `OPT_NONSH_ALL:     begin dom = sync_barrier_pkg::DOM_NONSHAREABLE; req.types = sync_barrier_pkg::TYP_ALL;    end
      `OPT_INNER_READS:   begin dom = sync_barrier_pkg::DOM_INNER; req.types = sync_barrier_pkg::TYP_READS;  end
      `OPT_INNER_WRITES:  begin dom = sync_barrier_pkg::DOM_INNER; req.types = sync_barrier_pkg::TYP_WRITES; end
      `OPT_INNER_ALL:     begin dom = sync_barrier_pkg::DOM_INNER; req.types = sync_barrier_pkg::TYP_ALL;    end
      `OPT_SYSTEM_READS:  begin dom = sync_barrier_pkg::DOM_FULL_SYSTEM; req.types = sync_barrier_pkg::TYP_READS;  end
      `OPT_SYSTEM_WRITES: begin dom = sync_barrier_pkg::DOM_FULL_SYSTEM; req.types = sync_barrier_pkg::TYP_WRITES; end
      // reserved codes and the full-barrier code land here
      default:            begin dom = sync_barrier_pkg::DOM_FULL_SYSTEM; req.types = sync_barrier_pkg::TYP_ALL; end
    endcase
    upgrade = req.hyp_present && !req.secure &&
              (req.level != sync_barrier_pkg::HYPERVISOR_LEVEL);
    req.domain = dom;
    if (upgrade && req.bsu == `BSU_SYSTEM) begin
      req.domain = sync_barrier_pkg::DOM_FULL_SYSTEM;
    end else if (upgrade && req.bsu == `BSU_OUTER &&
                 dom != sync_barrier_pkg::DOM_FULL_SYSTEM) begin
      req.domain = sync_barrier_pkg::DOM_OUTER;
    end else if (upgrade && req.bsu == `BSU_INNER &&
                 dom == sync_barrier_pkg::DOM_NONSHAREABLE) begin
      req.domain = sync_barrier_pkg::DOM_INNER;
    end
  end

endmodule : barrier_option_map

//--- test/sync_barrier_option_decoder_props.sv
`timescale 1ns/10ps

module sync_barrier_option_decoder_props #(
  parameter int VIRTUAL_MACHINE_IDENTIFIER_W = 8
) (
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic              ISSUE_VALID,
  input wire logic              ISSUE_READY,
  input wire logic [31:0]       INSTR,
  input wire logic              COND_PASS,
  input wire logic [1:0]        LEVEL,
  input wire logic              SECURE,
  input wire logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] VIRTUAL_MACHINE_IDENTIFIER,
  input wire logic              BAR_REQ,
  input wire logic              BAR_DONE,
  input wire logic [1:0]        BAR_DOMAIN,
  input wire logic [1:0]        BAR_TYPES,
  input wire logic              BAR_FULL,
  input wire logic [1:0]        BAR_SCOPE,
  input wire logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0] BAR_VIRTUAL_MACHINE_IDENTIFIER,
  input wire logic              RETIRE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // an instruction accepted at this edge, condition passed or not
  logic take;
  assign take = ISSUE_VALID && ISSUE_READY;

  //////////////////////////////////////////////////////////////////////////
  chk_busy_refuse: assert property (BAR_REQ |-> !ISSUE_READY)
    else $error("issue accepted while a barrier is outstanding");
  chk_skip_quiet: assert property (
    take && !COND_PASS |=> RETIRE && !BAR_REQ
      ##1 (!RETIRE || $past(take && !COND_PASS)))
    else $error("failed condition did not retire quietly");
  chk_pass_req: assert property (take && COND_PASS |=> BAR_REQ)
    else $error("passed condition raised no request");
  chk_done_retire: assert property (
    BAR_REQ && BAR_DONE |=> RETIRE && !BAR_REQ
      ##1 (!RETIRE || $past(take && !COND_PASS)))
    else $error("completion did not retire once");
  chk_attr_hold: assert property (
    BAR_REQ && !BAR_DONE |=> $stable(BAR_DOMAIN) && $stable(BAR_TYPES)
      && $stable(BAR_FULL) && $stable(BAR_VIRTUAL_MACHINE_IDENTIFIER))
    else $error("attributes moved during a request");
  chk_full_hyp: assert property (
    take && COND_PASS && INSTR[3:0] == 4'hC && LEVEL[1]
      |=> BAR_FULL && BAR_SCOPE == 2'h2)
    else $error("hypervisor full barrier not issued");
  chk_full_only_c: assert property (
    take && COND_PASS && (INSTR[3:0] != 4'hC || !LEVEL[1]) |=> !BAR_FULL)
    else $error("full barrier issued wrongly");
  chk_low_scope: assert property (
    take && COND_PASS && !LEVEL[1]
      |=> BAR_SCOPE == 2'h0 && BAR_VIRTUAL_MACHINE_IDENTIFIER == $past(VIRTUAL_MACHINE_IDENTIFIER))
    else $error("lower level scope or machine id wrong");
  chk_hyp_scope: assert property (
    take && COND_PASS && LEVEL[1] && INSTR[3:0] != 4'hC
      |=> BAR_SCOPE == 2'h1)
    else $error("hypervisor scope wrong");
  chk_secure_map: assert property (
    take && COND_PASS && SECURE && INSTR[3:0] == 4'h7
      |=> BAR_DOMAIN == 2'h0 && BAR_TYPES == 2'h3)
    else $error("secure non-shareable barrier upgraded");
endmodule : sync_barrier_option_decoder_props

bind sync_barrier_option_decoder sync_barrier_option_decoder_props
  #(.VIRTUAL_MACHINE_IDENTIFIER_W(VIRTUAL_MACHINE_IDENTIFIER_W)) sync_barrier_option_decoder_props_i (
  .CLK(CLK), .RSTN(RSTN), .ISSUE_VALID(ISSUE_VALID),
  .ISSUE_READY(ISSUE_READY), .INSTR(INSTR), .COND_PASS(COND_PASS),
  .LEVEL(LEVEL), .SECURE(SECURE), .VIRTUAL_MACHINE_IDENTIFIER(VIRTUAL_MACHINE_IDENTIFIER), .BAR_REQ(BAR_REQ),
  .BAR_DONE(BAR_DONE), .BAR_DOMAIN(BAR_DOMAIN), .BAR_TYPES(BAR_TYPES),
  .BAR_FULL(BAR_FULL), .BAR_SCOPE(BAR_SCOPE), .BAR_VIRTUAL_MACHINE_IDENTIFIER(BAR_VIRTUAL_MACHINE_IDENTIFIER),
  .RETIRE(RETIRE));

//--- test/barrier_completer.sv
`timescale 1ns/10ps

module barrier_completer (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       BAR_REQ,
  input  wire logic [7:0] LAG,
  output      logic       BAR_DONE
);
  logic [7:0] wait_q;

  // counts cycles of the outstanding request, restarts per request
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) wait_q <= 8'h00;
    else if (!BAR_REQ || BAR_DONE) wait_q <= 8'h00;
    else wait_q <= wait_q + 8'h01;
  end

  // completion only while a request stands; lag 0 answers at once
  assign BAR_DONE = BAR_REQ && (wait_q >= LAG);
endmodule : barrier_completer

//--- test/tb_sync_barrier_option_decoder.sv
`timescale 1ns/10ps

module tb_sync_barrier_option_decoder;
  logic        CLK, RSTN, ISSUE_VALID, ISSUE_READY, COND_PASS, SECURE;
  logic        BAR_REQ, BAR_DONE, BAR_FULL, RETIRE, HREADYOUT, HRESP;
  logic        HSEL, HWRITE;
  logic [31:0] INSTR, HADDR, HWDATA, HRDATA;
  logic [1:0]  LEVEL, HTRANS, BAR_DOMAIN, BAR_TYPES, BAR_SCOPE, bsu;
  logic [2:0]  HSIZE;
  logic [7:0]  VIRTUAL_MACHINE_IDENTIFIER, BAR_VIRTUAL_MACHINE_IDENTIFIER, lag;
  int          fails, n_compared, n_done, n_skip;

  sync_barrier_option_decoder #(.VIRTUAL_MACHINE_IDENTIFIER_W(8)) sync_barrier_option_decoder_i (
    .CLK(CLK), .RSTN(RSTN), .ISSUE_VALID(ISSUE_VALID),
    .ISSUE_READY(ISSUE_READY), .INSTR(INSTR), .COND_PASS(COND_PASS),
    .LEVEL(LEVEL), .SECURE(SECURE), .VIRTUAL_MACHINE_IDENTIFIER(VIRTUAL_MACHINE_IDENTIFIER), .BAR_REQ(BAR_REQ),
    .BAR_DONE(BAR_DONE), .BAR_DOMAIN(BAR_DOMAIN), .BAR_TYPES(BAR_TYPES),
    .BAR_FULL(BAR_FULL), .BAR_SCOPE(BAR_SCOPE), .BAR_VIRTUAL_MACHINE_IDENTIFIER(BAR_VIRTUAL_MACHINE_IDENTIFIER),
    .RETIRE(RETIRE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA));
  barrier_completer barrier_completer_i (.CLK(CLK), .RSTN(RSTN),
    .BAR_REQ(BAR_REQ), .LAG(lag), .BAR_DONE(BAR_DONE));

  // 50 MHz clock
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // bounded wait at falling edges: 0 issue ready, 1 bus ready, 2 retire
  task automatic await(input int w);
    int i;
    for (i = 0; i < 50; i++) begin
      @(negedge CLK);
      if ((w == 0 && ISSUE_READY === 1'b1) || (w == 1 && HREADYOUT === 1'b1)
          || (w == 2 && RETIRE === 1'b1)) break;
    end
    if (i == 50) begin
      fails++;
      summarize();
    end
  endtask : await

  // one single-word bus transfer, read data taken in the data phase
  task automatic ahb(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    await(1);
    @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    await(1);
    q = HRDATA;
    check({HREADYOUT, HRESP}, 2'b10);
  endtask : ahb

  // expected {domain, types} of an option before any upgrade
  function automatic logic [3:0] dec(input logic [3:0] o);
    if (o[1:0] == 2'h0 || o == 4'hF) return 4'hF;
    case (o[3:2])
      2'h0: return {2'h2, o[1:0]};
      2'h1: return {2'h0, o[1:0]};
      2'h2: return {2'h1, o[1:0]};
      default: return {2'h3, o[1:0]};
    endcase
  endfunction : dec

  function automatic logic [1:0] up(input logic [1:0] d, b);
    if (b == 2'h3) return 2'h3;
    if (b == 2'h2 && d != 2'h3) return 2'h2;
    if (b == 2'h1 && d == 2'h0) return 2'h1;
    return d;
  endfunction : up

  // issues one barrier, checks attributes, status and retirement
  task automatic bar(input logic [3:0] o, input logic [1:0] lv,
                     input logic sec, cnd, peek);
    logic [3:0]  dt;
    logic [1:0]  dm, sc;
    logic        fl;
    logic [7:0]  vm;
    logic [31:0] q;
    dt = dec(o);
    dm = dt[3:2];
    if (!sec && !lv[1]) dm = up(dm, bsu);
    fl = (o == 4'hC) && lv[1];
    sc = fl ? 2'h2 : (lv[1] ? 2'h1 : 2'h0);
    vm = VIRTUAL_MACHINE_IDENTIFIER + 8'h11;
    @(posedge CLK);
    ISSUE_VALID <= 1'b1;
    INSTR <= {28'hF57FF04, o};
    LEVEL <= lv;
    SECURE <= sec;
    COND_PASS <= cnd;
    VIRTUAL_MACHINE_IDENTIFIER <= vm;
    await(0);
    @(posedge CLK);
    ISSUE_VALID <= 1'b0;
    @(negedge CLK);
    if (!cnd) begin
      check({RETIRE, BAR_REQ}, 2'b10);
      n_skip++;
      return;
    end
    check({BAR_REQ, ISSUE_READY}, 2'b10);
    check({BAR_DOMAIN, BAR_TYPES}, {dm, dt[1:0]});
    check({BAR_FULL, BAR_SCOPE, BAR_VIRTUAL_MACHINE_IDENTIFIER}, {fl, sc, vm});
    if (peek) begin
      @(posedge CLK);
      VIRTUAL_MACHINE_IDENTIFIER <= ~vm;
      ahb(1'b0, 32'h4, 32'h0, q);
      check(q, {16'h0, vm, sc, fl, dt[1:0], dm, 1'b1});
    end
    await(2);
    n_done++;
    @(negedge CLK);
    check(RETIRE, 1'b0);
  endtask : bar

  //////////////////////////////////////////////////////////////////////////
  // reset values, read-only and unmapped places
  task automatic t_regs();
    // the unmapped word goes first so an aliased write shows in control
    logic [31:0] a [5] = '{32'h10, 32'h0, 32'h4, 32'h8, 32'hC};
    logic [31:0] e [5] = '{32'h0, 32'h0, 32'h1E, 32'h0, 32'h0};
    logic [31:0] q;
    foreach (a[i]) begin
      ahb(1'b0, a[i], 32'h0, q);
      check(q, e[i]);
      ahb(1'b1, a[i], 32'hFFFFFFFF, q);
      ahb(1'b0, a[i], 32'h0, q);
      check(q, (i == 1) ? 32'h3 : e[i]);
    end
  endtask : t_regs

  task automatic set_bsu(input logic [1:0] b);
    logic [31:0] q;
    ahb(1'b1, 32'h0, {30'h0, b}, q);
    bsu = b;
  endtask : set_bsu

  // every option at one lower level picked by its low bit, then each upgrade setting
  task automatic t_decode();
    logic [3:0] ups [4] = '{4'h7, 4'h9, 4'h3, 4'hF};
    set_bsu(2'h0);
    for (int o = 0; o < 16; o++) bar(o[3:0], {1'b0, o[0]}, 1'b1, 1'b1, 1'b0);
    for (int b = 0; b < 4; b++) begin
      set_bsu(b[1:0]);
      foreach (ups[i]) bar(ups[i], {1'b0, b[0]}, 1'b0, 1'b1, 1'b0);
      bar(4'h7, 2'h2, 1'b0, 1'b1, 1'b0);
      bar(4'hC, b[1:0] | 2'h2, 1'b0, 1'b1, 1'b0);
      bar(4'hC, 2'h1, 1'b0, 1'b1, 1'b0);
    end
  endtask : t_decode

  // skipped barriers back to back, then a slow completion with a status peek
  task automatic t_skip_slow();
    logic [31:0] q;
    bar(4'h3, 2'h1, 1'b1, 1'b0, 1'b0);
    bar(4'hC, 2'h2, 1'b0, 1'b0, 1'b0);
    lag <= 8'h08;
    bar(4'h9, 2'h0, 1'b1, 1'b1, 1'b1);
    ahb(1'b0, 32'h8, 32'h0, q);
    check(q, n_done);
    ahb(1'b0, 32'hC, 32'h0, q);
    check(q, n_skip);
  endtask : t_skip_slow

  initial begin
    {ISSUE_VALID, COND_PASS, SECURE, HSEL, HWRITE} = 5'h00;
    {INSTR, HADDR, HWDATA} = 96'h0;
    {LEVEL, HTRANS, bsu} = 6'h00;
    {VIRTUAL_MACHINE_IDENTIFIER, lag} = 16'h0000;
    HSIZE = 3'h2;
    {fails, n_compared, n_done, n_skip} = 128'h0;
    RSTN = 1'b0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    t_regs();
    t_decode();
    t_skip_slow();
    summarize();
  end
endmodule : tb_sync_barrier_option_decoder
